// *** hw/flash_guard_pkg.sv ***
// Purpose: shared constants and state types of the flash write/erase guard
// Assumes: 32 kbyte main block of 64 pages of 512 bytes
// Notes: all timing counts are in system clock cycles
package flash_guard_pkg;

   // ----------------------------------------------------------------
   // flash geometry
   // ----------------------------------------------------------------
   localparam int unsigned FLASH_ADDR_WIDTH = 15;
   localparam int unsigned PAGE_WIDTH = 6;
   localparam logic [7:0] PAGE_COUNT = 8'h40;
   localparam logic [5:0] DATA_PAGE_FIRST = 6'h3e;
   localparam logic [8:0] PAGE_OFFSET_ZERO = 9'h000;
   localparam logic [14:0] TOP_BYTES_BASE = 15'h7ff0;
   localparam logic [4:0] TOP_BYTES_COUNT = 5'h10;

   // ----------------------------------------------------------------
   // unlock sequence
   // ----------------------------------------------------------------
   localparam logic [7:0] UNLOCK_FIRST = 8'haa;
   localparam logic [7:0] UNLOCK_SECOND = 8'h55;
   localparam int unsigned COUNTDOWN_WIDTH = 7;
   localparam logic [6:0] COUNTDOWN_RELOAD = 7'h7f;

   // ----------------------------------------------------------------
   // operation timing
   // ----------------------------------------------------------------
   localparam int unsigned WRITE_CYCLES_DEFAULT = 740;
   localparam int unsigned ERASE_CYCLES_DEFAULT = 360000;
   localparam int unsigned OP_COUNT_WIDTH = 19;

   // ----------------------------------------------------------------
   // status register layout and reset values
   // ----------------------------------------------------------------
   localparam int unsigned STATUS_START_PROTECTED_BIT = 6;
   localparam int unsigned STATUS_WRITE_OPEN_BIT = 5;
   localparam int unsigned STATUS_READY_LOW_BIT = 4;
   localparam int unsigned STATUS_READBACK_BIT = 2;
   localparam logic [7:0] STATUS_RESET = 8'h00;
   localparam logic [15:0] BOOT_ADDRESS_RESET = 16'h0000;
   localparam logic [15:0] VECTOR_BASE = 16'h0000;

   typedef enum logic [1:0]
   {
      UNLOCK_IDLE = 2'b00,
      UNLOCK_ARMED = 2'b01,
      UNLOCK_WINDOW = 2'b10
   } unlock_state_type;

   typedef enum logic [1:0]
   {
      OP_BOOT_SCAN = 2'b00,
      OP_IDLE = 2'b01,
      OP_WRITE = 2'b10,
      OP_ERASE = 2'b11
   } op_state_type;

endpackage

// *** hw/unlock_countdown.sv ***
// Purpose: reloadable down counter that times one unlock window
// Assumes: load may arrive in any cycle, also while counting
// Notes: active stays high from the cycle after load until count zero
`timescale 1ns/1ps
module unlock_countdown
#(
   parameter int unsigned WIDTH = 7,
   parameter logic [WIDTH-1:0] RELOAD = '1
)
(
   input wire logic clock,
   input wire logic reset,
   input wire logic load,
   output logic active,
   output logic expired
);
   typedef struct packed
   {
      logic [WIDTH-1:0] count;
      logic active;
   } count_state_type;

   count_state_type state_reg;
   count_state_type state_next;

   if (WIDTH < 1 || WIDTH > 16)
   begin : g_bad_width
      $error("countdown width out of range");
   end

   always_comb
   begin
      state_next = state_reg;
      if (load)
      begin
         state_next.count = RELOAD;
         state_next.active = 1'b1;
      end
      else if (state_reg.active && state_reg.count == '0)
      begin
         state_next.active = 1'b0;
      end
      else if (state_reg.active)
      begin
         state_next.count = state_reg.count - 1'b1;
      end
   end

   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         state_reg <= '0;
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   assign active = state_reg.active;
   assign expired = state_reg.active && (state_reg.count == '0);

endmodule

// *** hw/mcu_flash_write_erase_guard.sv ***
// Purpose: guards processor byte writes and page erases of the flash main block
// Assumes: flash_rdata is valid the cycle after flash_read; inputs synchronous
// Notes: operations are self-timed; the core is stalled while running from flash
`timescale 1ns/1ps
// Overview of operation
// - each byte write keeps the core stalled for 740 cycles when running from flash
// - a page erase keeps the core stalled for up to 360,000 cycles when running from flash
// - interrupts are held off for as long as the core is stalled
// - writes and erases reach only unprotected pages and data pages
// - 0xaa to the command register starts the 127-to-0 countdown
// - 0x55 before expiry reloads the countdown to 127
// - write-open may be set only during the countdown after 0x55
// - write-open stays set until software clears it, clearing needs no unlock
// - with writes open, a command value 0-63 erases that page
// - one byte is programmed per processor write, no auto increment
// - each operation is self-timed with fetch stalled when running from flash
// - ready-low reads high while an operation runs, low when done
// - start-protected boots from page count shifted by 9, else address zero
// - at reset, odd ones in top 16 bytes with data area set start-protected
// - with the data area disabled, start-protected is cleared at reset
// - start-protected is read-only, changed only by the reset-time parity check
// - interrupt vectors always come from the first flash page
// - status bit 6 start-protected, bit 5 write-open, bit 4 ready-low
// - main-block readback disable blocks page erase and byte write
module mcu_flash_write_erase_guard
   import flash_guard_pkg::*;
#(
   parameter int unsigned WRITE_CYCLES = flash_guard_pkg::WRITE_CYCLES_DEFAULT,
   parameter int unsigned ERASE_CYCLES = flash_guard_pkg::ERASE_CYCLES_DEFAULT
)
(
   input wire logic clock,
   input wire logic reset,
   input wire logic command_write,
   input wire logic [7:0] command_data,
   input wire logic status_write,
   input wire logic [7:0] status_data,
   input wire logic byte_write_req,
   input wire logic [flash_guard_pkg::FLASH_ADDR_WIDTH-1:0] byte_write_addr,
   input wire logic [7:0] byte_write_data,
   input wire logic code_from_flash,
   input wire logic data_area_enable,
   input wire logic [6:0] unprotected_page_count,
   input wire logic main_readback_disable,
   input wire logic [7:0] flash_rdata,
   output logic [7:0] flash_status_reg,
   output logic core_stall,
   output logic interrupt_hold,
   output logic [15:0] boot_address,
   output logic [15:0] vector_base_address,
   output logic boot_done,
   output logic [flash_guard_pkg::FLASH_ADDR_WIDTH-1:0] flash_addr,
   output logic [7:0] flash_wdata,
   output logic flash_program,
   output logic flash_erase,
   output logic flash_read
);
   import flash_guard_pkg::*;

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed
   {
      unlock_state_type unlock;
      op_state_type op;
      logic write_open;
      logic start_protected;
      logic parity;
      logic [4:0] scan_index;
      logic read_pending;
      logic [OP_COUNT_WIDTH-1:0] op_count;
      logic core_stall;
      logic interrupt_hold;
      logic [7:0] flash_status;
      logic [15:0] boot_address;
      logic [15:0] vector_base;
      logic [FLASH_ADDR_WIDTH-1:0] flash_addr;
      logic [7:0] flash_wdata;
      logic flash_program;
      logic flash_erase;
      logic flash_read;
      logic boot_done;
   } state_type;

   localparam state_type STATE_RESET = '{
      unlock: UNLOCK_IDLE,
      op: OP_BOOT_SCAN,
      write_open: 1'b0,
      start_protected: 1'b0,
      parity: 1'b0,
      scan_index: 5'h00,
      read_pending: 1'b0,
      op_count: '0,
      core_stall: 1'b1,
      interrupt_hold: 1'b1,
      flash_status: STATUS_RESET,
      boot_address: BOOT_ADDRESS_RESET,
      vector_base: VECTOR_BASE,
      flash_addr: '0,
      flash_wdata: 8'h00,
      flash_program: 1'b0,
      flash_erase: 1'b0,
      flash_read: 1'b0,
      boot_done: 1'b0
   };

   state_type state_reg;
   state_type state_next;
   logic countdown_load;
   logic countdown_active;
   logic countdown_expired;
   logic busy_next;
   logic write_allowed;
   logic erase_allowed;

   if (WRITE_CYCLES < 2 || ERASE_CYCLES < 2 || ERASE_CYCLES >= (1 << OP_COUNT_WIDTH)
      || WRITE_CYCLES >= (1 << OP_COUNT_WIDTH))
   begin : g_bad_cycles
      $error("operation cycle counts out of range");
   end

   // pages below the unprotected count, plus the two data pages when enabled
   function automatic logic page_allowed(input logic [PAGE_WIDTH-1:0] page,
                                         input logic [6:0] count,
                                         input logic data_area);
      page_allowed = (data_area && page >= DATA_PAGE_FIRST) || ({1'b0, page} < count);
   endfunction

   // ----------------------------------------------------------------
   // unlock window timer
   // ----------------------------------------------------------------
   unlock_countdown
   #(
      .WIDTH(COUNTDOWN_WIDTH),
      .RELOAD(COUNTDOWN_RELOAD)
   )
   countdown
   (
      .clock(clock),
      .reset(reset),
      .load(countdown_load),
      .active(countdown_active),
      .expired(countdown_expired)
   );

   always_comb
   begin
      write_allowed = state_reg.write_open && !main_readback_disable
         && page_allowed(byte_write_addr[FLASH_ADDR_WIDTH-1 -: PAGE_WIDTH],
                         unprotected_page_count, data_area_enable);
      erase_allowed = state_reg.write_open && !main_readback_disable
         && command_data < PAGE_COUNT
         && page_allowed(command_data[PAGE_WIDTH-1:0],
                         unprotected_page_count, data_area_enable);
   end

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb
   begin
      state_next = state_reg;
      countdown_load = 1'b0;
      state_next.flash_program = 1'b0;
      state_next.flash_erase = 1'b0;
      state_next.flash_read = 1'b0;
      state_next.read_pending = state_reg.flash_read;

      // unlock sequence
      if (command_write)
      begin
         unique case (state_reg.unlock)
            UNLOCK_IDLE:
            begin
               if (command_data == UNLOCK_FIRST)
               begin
                  countdown_load = 1'b1;
                  state_next.unlock = UNLOCK_ARMED;
               end
            end
            UNLOCK_ARMED:
            begin
               if (countdown_active && command_data == UNLOCK_SECOND)
               begin
                  countdown_load = 1'b1;
                  state_next.unlock = UNLOCK_WINDOW;
               end
               else if (command_data == UNLOCK_FIRST)
               begin
                  countdown_load = 1'b1;
               end
               else
               begin
                  state_next.unlock = UNLOCK_IDLE;
               end
            end
            UNLOCK_WINDOW:
            begin
               if (command_data == UNLOCK_FIRST)
               begin
                  countdown_load = 1'b1;
                  state_next.unlock = UNLOCK_ARMED;
               end
            end
            default:
            begin
               state_next.unlock = UNLOCK_IDLE;
            end
         endcase
      end
      else if (countdown_expired)
      begin
         state_next.unlock = UNLOCK_IDLE;
      end

      // write-open flag: clear always allowed, set only inside the window
      if (status_write)
      begin
         if (!status_data[STATUS_WRITE_OPEN_BIT])
         begin
            state_next.write_open = 1'b0;
         end
         else if (state_reg.unlock == UNLOCK_WINDOW && countdown_active)
         begin
            state_next.write_open = 1'b1;
            state_next.unlock = UNLOCK_IDLE;
         end
      end

      // operations
      unique case (state_reg.op)
         OP_BOOT_SCAN:
         begin
            if (state_reg.scan_index < TOP_BYTES_COUNT)
            begin
               state_next.flash_read = 1'b1;
               state_next.flash_addr = TOP_BYTES_BASE
                  + FLASH_ADDR_WIDTH'(state_reg.scan_index);
               state_next.scan_index = state_reg.scan_index + 5'h01;
            end
            if (state_reg.read_pending)
            begin
               state_next.parity = state_reg.parity ^ (^flash_rdata);
            end
            else if (state_reg.scan_index == TOP_BYTES_COUNT && !state_reg.flash_read)
            begin
               // parity sets the flag only with the data area on
               state_next.start_protected = data_area_enable && state_reg.parity;
               state_next.boot_address = (data_area_enable && state_reg.parity)
                  ? {unprotected_page_count, PAGE_OFFSET_ZERO} : BOOT_ADDRESS_RESET;
               state_next.vector_base = VECTOR_BASE;
               state_next.boot_done = 1'b1;
               state_next.op = OP_IDLE;
            end
         end
         OP_IDLE:
         begin
            if (byte_write_req && write_allowed)
            begin
               state_next.flash_program = 1'b1;
               state_next.flash_addr = byte_write_addr;
               state_next.flash_wdata = byte_write_data;
               state_next.op_count = OP_COUNT_WIDTH'(WRITE_CYCLES);
               state_next.op = OP_WRITE;
            end
            else if (command_write && erase_allowed)
            begin
               state_next.flash_erase = 1'b1;
               state_next.flash_addr = {command_data[PAGE_WIDTH-1:0], PAGE_OFFSET_ZERO};
               state_next.op_count = OP_COUNT_WIDTH'(ERASE_CYCLES);
               state_next.op = OP_ERASE;
            end
         end
         OP_WRITE, OP_ERASE:
         begin
            // self-timed: the operation ends on its own count
            if (state_reg.op_count == OP_COUNT_WIDTH'(1))
            begin
               state_next.op = OP_IDLE;
            end
            else
            begin
               state_next.op_count = state_reg.op_count - OP_COUNT_WIDTH'(1);
            end
         end
      endcase

      busy_next = (state_next.op == OP_WRITE) || (state_next.op == OP_ERASE);
      state_next.core_stall = (state_next.op == OP_BOOT_SCAN)
         || (busy_next && code_from_flash);
      state_next.interrupt_hold = state_next.core_stall;
      state_next.flash_status = 8'h00;
      state_next.flash_status[STATUS_START_PROTECTED_BIT] = state_next.start_protected;
      state_next.flash_status[STATUS_WRITE_OPEN_BIT] = state_next.write_open;
      state_next.flash_status[STATUS_READY_LOW_BIT] = busy_next;
      state_next.flash_status[STATUS_READBACK_BIT] = main_readback_disable;
   end

   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         state_reg <= STATE_RESET;
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign flash_status_reg = state_reg.flash_status;
   assign core_stall = state_reg.core_stall;
   assign interrupt_hold = state_reg.interrupt_hold;
   assign boot_address = state_reg.boot_address;
   assign vector_base_address = state_reg.vector_base;
   assign boot_done = state_reg.boot_done;
   assign flash_addr = state_reg.flash_addr;
   assign flash_wdata = state_reg.flash_wdata;
   assign flash_program = state_reg.flash_program;
   assign flash_erase = state_reg.flash_erase;
   assign flash_read = state_reg.flash_read;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   logic [OP_COUNT_WIDTH-1:0] busy_len;
   logic last_erase;

   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         busy_len <= '0;
         last_erase <= 1'b0;
      end
      else if (flash_program || flash_erase)
      begin
         busy_len <= OP_COUNT_WIDTH'(1);
         last_erase <= flash_erase;
      end
      else if (flash_status_reg[STATUS_READY_LOW_BIT])
      begin
         busy_len <= busy_len + OP_COUNT_WIDTH'(1);
      end
   end

   default clocking @(posedge clock); endclocking
   default disable iff (reset);

   property p_write_length;
      $fell(flash_status_reg[STATUS_READY_LOW_BIT]) && !last_erase
         |-> busy_len == OP_COUNT_WIDTH'(WRITE_CYCLES);
   endproperty
   a_write_length: assert property (p_write_length) else $error("write length wrong");

   property p_erase_length;
      $fell(flash_status_reg[STATUS_READY_LOW_BIT]) && last_erase
         |-> busy_len == OP_COUNT_WIDTH'(ERASE_CYCLES);
   endproperty
   a_erase_length: assert property (p_erase_length) else $error("erase length wrong");

   property p_irq_held;
      flash_status_reg[STATUS_READY_LOW_BIT] && $past(code_from_flash)
         |-> core_stall && interrupt_hold;
   endproperty
   a_irq_held: assert property (p_irq_held) else $error("interrupts not held");

   property p_protected_page;
      flash_program |-> page_allowed(flash_addr[FLASH_ADDR_WIDTH-1 -: PAGE_WIDTH],
         $past(unprotected_page_count), $past(data_area_enable));
   endproperty
   a_protected_page: assert property (p_protected_page) else $error("protected page written");

   property p_set_outside_window;
      status_write && status_data[STATUS_WRITE_OPEN_BIT] && !flash_status_reg[STATUS_WRITE_OPEN_BIT]
         && state_reg.unlock != UNLOCK_WINDOW |=> !flash_status_reg[STATUS_WRITE_OPEN_BIT];
   endproperty
   a_set_outside_window: assert property (p_set_outside_window) else $error("open outside window");

   property p_full_unlock;
      command_write && command_data == UNLOCK_FIRST && state_reg.unlock == UNLOCK_IDLE
         ##1 command_write && command_data == UNLOCK_SECOND
         ##1 status_write && status_data[STATUS_WRITE_OPEN_BIT]
         |=> flash_status_reg[STATUS_WRITE_OPEN_BIT];
   endproperty
   a_full_unlock: assert property (p_full_unlock) else $error("unlock failed");

   property p_open_holds;
      flash_status_reg[STATUS_WRITE_OPEN_BIT] && !status_write
         |=> flash_status_reg[STATUS_WRITE_OPEN_BIT];
   endproperty
   a_open_holds: assert property (p_open_holds) else $error("write-open dropped");

   property p_erase_start;
      command_write && erase_allowed && state_reg.op == OP_IDLE && !byte_write_req
         |=> flash_erase && flash_status_reg[STATUS_READY_LOW_BIT];
   endproperty
   a_erase_start: assert property (p_erase_start) else $error("erase not started");

   property p_readback_block;
      main_readback_disable |=> !flash_program && !flash_erase;
   endproperty
   a_readback_block: assert property (p_readback_block) else $error("blocked op started");

   property p_boot_choice;
      $rose(boot_done) |-> boot_address == (start_protected_check()
         ? {$past(unprotected_page_count), PAGE_OFFSET_ZERO} : BOOT_ADDRESS_RESET);
   endproperty
   a_boot_choice: assert property (p_boot_choice) else $error("boot address wrong");

   function automatic logic start_protected_check();
      start_protected_check = flash_status_reg[STATUS_START_PROTECTED_BIT];
   endfunction

   property p_flag_stable;
      boot_done && $past(boot_done) |-> $stable(flash_status_reg[STATUS_START_PROTECTED_BIT]);
   endproperty
   a_flag_stable: assert property (p_flag_stable) else $error("start-protected changed");

   c_write: cover property (flash_program ##1 flash_status_reg[STATUS_READY_LOW_BIT]);
   c_erase: cover property (flash_erase);
   c_open: cover property ($rose(flash_status_reg[STATUS_WRITE_OPEN_BIT]));
   c_boot_protected: cover property ($rose(boot_done) && start_protected_check());

endmodule

// *** verif/flash_model.sv ***
// Purpose: flash macro model answering the guard's reset-time scan reads
// Assumes: read data is due the cycle after flash_read
// Notes: only the top byte holds a one bit, so the top 16 bytes have odd parity
`timescale 1ns/1ps
module flash_model
(
   input wire logic clock,
   input wire logic flash_read,
   input wire logic [14:0] flash_addr,
   output logic [7:0] flash_rdata = 8'h00
);
   // -----------------------------------------------------------
   // read port, scrambled when not read
   // -----------------------------------------------------------
   always @(posedge clock)
   begin
      if (flash_read)
         flash_rdata <= (flash_addr == 15'h7fff) ? 8'h01 : 8'h00;
      else
         flash_rdata <= ~flash_rdata;
   end
endmodule

// *** verif/testbench.sv ***
// Purpose: self-checking bench of the flash write and erase guard
// Assumes: shortened write and erase times
// Notes: code runs from flash so stalls show at the ports
`timescale 1ns/1ps
module testbench;
   import flash_guard_pkg::*;
   localparam int WC = 20;
   localparam int EC = 50;
   logic clock = 0, reset = 1, cw = 0, sw_en = 0, bwr = 0, dae = 1, rbd = 0;
   logic [7:0] cd = 8'h00, sd = 8'h00, bwd = 8'h00, rdata, st;
   logic [14:0] bwa = 15'h0000, fa;
   logic [6:0] upc = 7'h04;
   logic stall, ihold, done, prog, ers, rd;
   logic [15:0] boot, vec;
   logic [7:0] wdata;
   int n_errors = 0, cmp_count = 0;
   always #5 clock = ~clock;
   mcu_flash_write_erase_guard #(.WRITE_CYCLES(WC), .ERASE_CYCLES(EC)) DUT (.clock(clock),
      .reset(reset), .command_write(cw), .command_data(cd), .status_write(sw_en),
      .status_data(sd), .byte_write_req(bwr), .byte_write_addr(bwa), .byte_write_data(bwd),
      .code_from_flash(1'b1), .data_area_enable(dae), .unprotected_page_count(upc),
      .main_readback_disable(rbd), .flash_rdata(rdata), .flash_status_reg(st),
      .core_stall(stall), .interrupt_hold(ihold), .boot_address(boot),
      .vector_base_address(vec), .boot_done(done), .flash_addr(fa), .flash_wdata(wdata),
      .flash_program(prog), .flash_erase(ers), .flash_read(rd));
   flash_model partner (.clock(clock), .flash_read(rd), .flash_addr(fa), .flash_rdata(rdata));
   // -----------------------------------------------------------
   // helpers
   // -----------------------------------------------------------
   task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      cmp_count++;
      if (got !== exp)
      begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task give_verdict;
      $display("errors %0d comparisons %0d", n_errors, cmp_count);
      if (n_errors == 0 && cmp_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task cyc(input int n);
      repeat (n) @(posedge clock);
   endtask
   task cmd(input logic [7:0] d);
      @(posedge clock);
      cw <= 1'b1;
      cd <= d;
      @(posedge clock);
      cw <= 1'b0;
   endtask
   task stw(input logic [7:0] d, input logic exp5);
      @(posedge clock);
      sw_en <= 1'b1;
      sd <= d;
      @(posedge clock);
      sw_en <= 1'b0;
      @(posedge clock);
      #1 chk("write_open", {15'h0, exp5}, {15'h0, st[5]});
   endtask
   task do_reset(input logic area, input logic exp6, input logic [15:0] eboot);
      int i;
      dae <= area;
      reset <= 1'b1;
      cyc(6);
      reset <= 1'b0;
      for (i = 0; i < 100 && done !== 1'b1; i++)
         cyc(1);
      #1 chk("boot_done", 16'h1, {15'h0, done});
      chk("start_protected", {15'h0, exp6}, {15'h0, st[6]});
      chk("boot_address", eboot, boot);
      chk("vector_base", 16'h0000, vec);
   endtask
   // a byte write (er=0) or page erase (er=1) and its stall
   task op(input logic er, input logic [14:0] a, input logic go);
      int i, n, seen;
      logic [14:0] ea;
      seen = 0;
      n = 0;
      ea = er ? {a[14:9], 9'h000} : a;
      @(posedge clock);
      if (er)
      begin
         cw <= 1'b1;
         cd <= {2'b00, a[14:9]};
      end
      else
      begin
         bwr <= 1'b1;
         bwa <= a;
         bwd <= 8'h3c;
      end
      @(posedge clock);
      cw <= 1'b0;
      bwr <= 1'b0;
      for (i = 0; i < 3; i++)
      begin
         #1 if ((er ? ers : prog) === 1'b1)
         begin
            seen++;
            chk("flash_addr", {1'b0, ea}, {1'b0, fa});
            if (!er)
               chk("flash_wdata", 16'h003c, {8'h00, wdata});
         end
         @(posedge clock);
      end
      for (i = 0; i < EC + 10 && (st[4] === 1'b1 || i == 0); i++)
      begin
         #1 if (st[4] === 1'b1)
         begin
            n++;
            chk("stall", 16'h1, {15'h0, stall});
            chk("irq_hold", 16'h1, {15'h0, ihold});
         end
         @(posedge clock);
      end
      chk("op_started", {15'h0, go}, seen[15:0]);
      chk("busy_cycles", go ? (er ? EC[15:0] : WC[15:0]) - 16'd3 : 16'd0,
         n[15:0]);
      #1 chk("stall_end", 16'h0, {15'h0, stall});
   endtask
   // -----------------------------------------------------------
   // scenarios
   // -----------------------------------------------------------
   initial
   begin
      do_reset(1'b1, 1'b1, 16'h0800);
      stw(8'h00, 1'b0);
      chk("ro_flag", 16'h1, {15'h0, st[6]});
      stw(8'h20, 1'b0);
      cmd(8'haa);
      cmd(8'h55);
      stw(8'h20, 1'b1);
      op(1'b0, 15'h0234, 1'b1);
      op(1'b0, 15'h1400, 1'b0);
      op(1'b0, 15'h7c01, 1'b1);
      op(1'b1, 15'h0400, 1'b1);
      rbd <= 1'b1;
      cyc(2);
      #1 chk("readback_bit", 16'h1, {15'h0, st[2]});
      op(1'b0, 15'h0010, 1'b0);
      op(1'b1, 15'h0200, 1'b0);
      rbd <= 1'b0;
      stw(8'h00, 1'b0);
      op(1'b0, 15'h0010, 1'b0);
      cmd(8'haa);
      cmd(8'h55);
      cyc(140);
      stw(8'h20, 1'b0);
      cmd(8'haa);
      cyc(140);
      cmd(8'h55);
      stw(8'h20, 1'b0);
      do_reset(1'b0, 1'b0, 16'h0000);
      give_verdict();
   end
   initial
   begin
      #200000;
      n_errors++;
      give_verdict();
   end
endmodule
